// ==== hdl/qec_pkg.sv ====
package qec_pkg;

  // widths of the counting datapath
  localparam int unsigned QEC_CNT_W   = 16;
  localparam int unsigned QEC_NCH     = 3;
  localparam int unsigned QEC_ADDR_W  = 4;
  localparam int unsigned QEC_DATA_W  = 8;

  // byte port offsets in the 16-byte block
  localparam logic [3:0] QEC_OFF_BOARD_RESET = 4'hb;  // write any value: local reset
  localparam logic [3:0] QEC_OFF_CMD         = 4'he;  // write: encoder_command_port
  localparam logic [3:0] QEC_OFF_HELD_LO     = 4'he;  // read: held_count_low_byte
  localparam logic [3:0] QEC_OFF_HELD_HI     = 4'hf;  // read: held_count_high_byte

  // encoder_command_port field layout
  localparam int unsigned QEC_CMD_SEL_LSB = 0;  // channel_select_lower
  localparam int unsigned QEC_CMD_SEL_MSB = 1;  // channel_select_upper
  localparam int unsigned QEC_CMD_OP_BIT  = 2;  // 0 latch, 1 reset

  // values after reset
  localparam logic [15:0] QEC_CNT_RST   = 16'h0000;
  localparam logic [15:0] QEC_HELD_RST  = 16'h0000;
  localparam logic [7:0]  QEC_RDATA_RST = 8'h00;
  localparam logic [7:0]  QEC_RDATA_UNM = 8'h00;  // answer for offsets not served here

  // channel select codes
  typedef enum logic [1:0] {
    QEC_SEL_CH0  = 2'b00,
    QEC_SEL_CH1  = 2'b01,
    QEC_SEL_CH2  = 2'b10,
    QEC_SEL_RSVD = 2'b11
  } qec_sel_t;

  typedef enum logic {
    QEC_OP_LATCH = 1'b0,
    QEC_OP_RESET = 1'b1
  } qec_op_t;

  // one bus cycle on the byte-wide port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } qec_io_req_t;

  // decoded strobes of one bus cycle
  typedef struct packed {
    logic     soft_rst;
    logic     cmd_valid;
    qec_op_t  op;
    qec_sel_t sel;
    logic     rd_lo;
    logic     rd_hi;
    logic     rd_other;
  } qec_dec_t;

  // phase pair of one encoder
  typedef struct packed {
    logic a;
    logic b;
  } qec_phase_t;

  // true for a channel code that names a fitted channel
  function automatic logic qec_sel_ok(input logic [1:0] sel);
    qec_sel_ok = (sel != QEC_SEL_RSVD);
  endfunction

endpackage

// ==== hdl/qec_port_decode.sv ====
`timescale 1ns/1ps
module qec_port_decode
  import qec_pkg::*;
(
  input  wire qec_io_req_t req,
  output qec_dec_t         dec
);

  // address decode of one byte-port cycle
  always_comb begin
    dec          = '0;
    dec.sel      = qec_sel_t'(req.wdata[QEC_CMD_SEL_MSB:QEC_CMD_SEL_LSB]);
    dec.op       = qec_op_t'(req.wdata[QEC_CMD_OP_BIT]);
    if (req.wr && req.addr == QEC_OFF_BOARD_RESET) begin
      dec.soft_rst = 1'b1;  // R19
    end else if (req.wr && req.addr == QEC_OFF_CMD) begin
      dec.cmd_valid = qec_sel_ok(req.wdata[QEC_CMD_SEL_MSB:QEC_CMD_SEL_LSB]);  // R10 R20
    end
    if (req.rd && req.addr == QEC_OFF_HELD_LO) begin
      dec.rd_lo = 1'b1;
    end else if (req.rd && req.addr == QEC_OFF_HELD_HI) begin
      dec.rd_hi = 1'b1;
    end else if (req.rd) begin
      dec.rd_other = 1'b1;
    end
  end

endmodule

// ==== hdl/qec_channel.sv ====
`timescale 1ns/1ps
module qec_channel
  import qec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        clr,
  input  wire qec_phase_t  phase,
  output logic [15:0]      count
);

  qec_phase_t  meta_q, meta_d;
  qec_phase_t  sync_q, sync_d;
  logic        a_prev_q, a_prev_d;
  logic [15:0] cnt_q, cnt_d;
  logic        a_edge;
  logic        dir_up;

  // edge on either sense of phase A; B only steers the direction
  assign a_edge = sync_q.a ^ a_prev_q;  // R2
  // A leads B when A differs from B right after an A edge
  assign dir_up = sync_q.a ^ sync_q.b;  // R1 R3

  // next values for synchroniser, edge memory and counter
  always_comb begin
    meta_d   = phase;
    sync_d   = meta_q;  // R18
    a_prev_d = sync_q.a;
    cnt_d    = cnt_q;
    if (clr) begin
      cnt_d = QEC_CNT_RST;  // R12 R19
    end else if (a_edge && dir_up) begin
      cnt_d = cnt_q + 16'h0001;  // R6 R8
    end else if (a_edge) begin
      cnt_d = cnt_q - 16'h0001;  // R7 R8
    end
  end

  // registers; counting is held while reset is low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // synchroniser and edge memory follow the pins, so a release makes no false edge
      meta_q   <= meta_d;
      sync_q   <= sync_d;
      a_prev_q <= a_prev_d;
      cnt_q    <= QEC_CNT_RST;  // R4 R5
    end else if (clk_en) begin
      meta_q   <= meta_d;
      sync_q   <= sync_d;
      a_prev_q <= a_prev_d;
      cnt_q    <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule

// ==== hdl/qec_top.sv ====
`timescale 1ns/1ps
// What this block does
// [R1] count up when phase A leads B, down when B leads A
// [R2] count on both edges of phase A; B only sets direction
// [R3] each A edge counted in the direction B shows then; no drift
// [R4] hard or soft reset clears all three counters and the holding register
// [R5] counting held during reset, resumes when reset ends
// [R6] counting up wraps ffff to 0000
// [R7] counting down wraps 0000 to ffff
// [R8] wrap raises no flag or interrupt
// [R9] host samples often enough that no counter wraps twice between samples
// [R10] one command write carries channel and operation
// [R11] latch copies the selected live count into the holding register
// [R12] reset command clears only the selected counter
// [R13] host latches before reading; reads return only the held copy
// [R14] select 00, 01, 10 pick channels 0, 1, 2; 11 reserved
// [R15] offset 14 reads bits 7..0, offset 15 reads bits 15..8
// [R16] bytes readable in any order; reads change nothing
// [R17] held value stays until the next latch or a reset
// [R18] phases synchronised to the clock before edge detection
// [R19] any write to offset 11 causes a local reset of the counters
// [R20] operation bit beside the select bits; reserved select ignored
module qec_top
  import qec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [3:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic [2:0]  enc_a,
  input  wire logic [2:0]  enc_b,
  output logic [7:0]       io_rdata,
  output logic             io_rvalid,
  output logic             local_reset
);

  qec_io_req_t req;
  qec_dec_t    dec;
  logic [15:0] count [QEC_NCH];
  logic [2:0]  ch_clr;
  logic [15:0] held_q, held_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        srst_q, srst_d;

  // gather the byte-port cycle
  assign req = '{wr: io_wr, rd: io_rd, addr: io_addr, wdata: io_wdata};

  qec_port_decode u_decode (
    .req (req),
    .dec (dec)
  );

  // true when this cycle carries a valid command of the given kind
  function automatic logic cmd_hit(input qec_dec_t d, input qec_op_t op);
    cmd_hit = d.cmd_valid && (d.op == op);  // R10
  endfunction

  // per-channel clear: board reset or a reset command for that channel
  always_comb begin
    for (int i = 0; i < QEC_NCH; i++) begin
      ch_clr[i] = srst_q  // R4 R19
        || (cmd_hit(dec, QEC_OP_RESET) && dec.sel == qec_sel_t'(2'(i)));  // R12 R14
    end
  end

  // three encoder channels
  for (genvar g = 0; g < QEC_NCH; g++) begin : g_ch
    qec_phase_t ph;

    // phase pair of this channel
    assign ph = '{a: enc_a[g], b: enc_b[g]};

    qec_channel u_ch (
      .clk    (clk),
      .resetn (resetn),
      .clk_en (clk_en),
      .clr    (ch_clr[g]),
      .phase  (ph),
      .count  (count[g])
    );
  end

  // holding register, soft reset pulse and read answer
  always_comb begin
    held_d   = held_q;
    srst_d   = dec.soft_rst;  // R19
    rvalid_d = dec.rd_lo | dec.rd_hi | dec.rd_other;
    rdata_d  = rdata_q;
    if (srst_q) begin
      held_d = QEC_HELD_RST;  // R4
    end else if (cmd_hit(dec, QEC_OP_LATCH)) begin
      case (dec.sel)
        QEC_SEL_CH0: held_d = count[0];  // R11 R14
        QEC_SEL_CH1: held_d = count[1];
        QEC_SEL_CH2: held_d = count[2];
        default:     held_d = held_q;  // R20
      endcase
    end
    // reads only see the held copy and never change it
    if (dec.rd_lo) begin
      rdata_d = held_q[7:0];  // R13 R15 R16
    end else if (dec.rd_hi) begin
      rdata_d = held_q[15:8];  // R15 R16
    end else if (dec.rd_other) begin
      rdata_d = QEC_RDATA_UNM;
    end
  end

  // registers; held value changes only on latch or reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      held_q   <= QEC_HELD_RST;  // R4 R17
      srst_q   <= 1'b0;
      rdata_q  <= QEC_RDATA_RST;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      held_q   <= held_d;  // R17
      srst_q   <= srst_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign io_rdata    = rdata_q;
  assign io_rvalid   = rvalid_q;
  assign local_reset = srst_q;

endmodule

// ==== verification/qec_enc_model.sv ====
`timescale 1ns/1ps
module qec_enc_model (
  input  wire logic [2:0] step,
  input  wire logic       clk,
  input  wire logic       fwd,
  output logic [2:0]      enc_a,
  output logic [2:0]      enc_b
);
  logic [1:0] st [3] = '{2'd0, 2'd0, 2'd0};
  // forward walk 00,10,11,01 puts A ahead of B
  always @(posedge clk) begin
    foreach (st[i]) if (step[i]) st[i] <= fwd ? st[i] + 2'd1 : st[i] - 2'd1;
  end
  // phase levels from the walk position
  always_comb foreach (st[i]) {enc_a[i], enc_b[i]} = {^st[i], st[i][1]};
endmodule

// ==== verification/qec_top_asserts.sv ====
`timescale 1ns/1ps
module qec_top_asserts
  import qec_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic [3:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [2:0] enc_a,
  input wire logic [2:0] enc_b,
  input wire logic [7:0] io_rdata,
  input wire logic       io_rvalid,
  input wire logic       local_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // taken reads, soft reset writes, high byte reads
  wire rd = io_rd && clk_en;
  wire sr = io_wr && clk_en && io_addr == QEC_OFF_BOARD_RESET;
  wire hi = rd && !io_wr && io_addr == QEC_OFF_HELD_HI;
  // two high byte reads with an idle cycle between
  sequence s_reread;
    !io_wr ##1 hi ##1 !io_wr ##1 hi;
  endsequence
  // soft reset, idle, then a held byte read
  sequence s_clear_read;
    sr ##1 clk_en && !io_wr ##1 rd && !io_wr && io_addr[3:1] == 3'b111;
  endsequence
  a_read_answer: assert property (rd |=> io_rvalid)
    else $error("read unanswered");
  a_no_stray_answer: assert property (!rd && clk_en |=> !io_rvalid)
    else $error("stray answer");
  a_soft_reset_pulse: assert property (sr |=> local_reset)
    else $error("no local reset");
  a_no_stray_reset: assert property (!sr && clk_en |=> !local_reset)
    else $error("stray local reset");
  a_rdata_kept: assert property (!rd |=> $stable(io_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (rd && io_addr < 4'he |=> io_rdata == QEC_RDATA_UNM)
    else $error("unmapped read");
  a_reread_same: assert property (s_reread |=> io_rdata == $past(io_rdata, 2))
    else $error("reread differs");
  a_soft_clear: assert property (s_clear_read |=> io_rdata == 8'h00)
    else $error("held not cleared");
endmodule
bind qec_top qec_top_asserts chk (.clk(clk), .resetn(resetn), .clk_en(clk_en), .io_wr(io_wr),
  .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .enc_a(enc_a), .enc_b(enc_b),
  .io_rdata(io_rdata), .io_rvalid(io_rvalid), .local_reset(local_reset));

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import qec_pkg::*;
  logic clk = 0, resetn = 0, clk_en = 1, io_wr = 0, io_rd = 0, fwd = 0, io_rvalid, local_reset;
  logic [3:0] io_addr = 4'h0;
  logic [7:0] io_wdata = 8'h00, io_rdata, b;
  logic [2:0] enc_a, enc_b, step = 3'h0;
  logic [15:0] ec [3];
  logic [1:0] sq [3] = '{2'd0, 2'd0, 2'd0};
  int mismatches = 0, samples_checked = 0;
  always #20 clk = ~clk;
  qec_top uut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .enc_a(enc_a), .enc_b(enc_b),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .local_reset(local_reset));
  qec_enc_model enc (.step(step), .clk(clk), .fwd(fwd), .enc_a(enc_a), .enc_b(enc_b));
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // one byte port cycle; a read leaves its answer in b
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
    @(negedge clk);
    {io_wr, io_rd} = 2'b00;
    b = io_rdata;
    if (!w) chk(io_rvalid, 1);
  endtask
  task automatic rd16(input bit h, input logic [15:0] v);
    bus(0, {3'b111, h}, 0);
    chk(b, h ? v[15:8] : v[7:0]);
    bus(0, {3'b111, !h}, 0);
    chk(b, h ? v[7:0] : v[15:8]);
  endtask
  task automatic peek(input int c, input bit h);
    bus(1, QEC_OFF_CMD, 8'(c));
    rd16(h, ec[c]);
  endtask
  // walk one encoder n quarter steps, tracking the expected count
  task automatic mv(input int c, input bit f, input int n);
    repeat (n) begin
      @(negedge clk);
      {step[c], fwd} = {1'b1, f};
      if (sq[c][0] != f) ec[c] = f ? ec[c] + 16'h1 : ec[c] - 16'h1;
      sq[c] = f ? sq[c] + 2'd1 : sq[c] - 2'd1;
      @(negedge clk);
      step[c] = 0;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic hrst();
    resetn = 0;
    repeat (20) @(negedge clk);
    resetn = 1;
    ec = '{16'h0, 16'h0, 16'h0};
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    hrst();
    for (int i = 0; i < 3; i++) peek(i, 0);
    $display("reset test done");
    mv(0, 1, 6);
    mv(1, 1, 1);
    mv(1, 0, 1);
    mv(1, 1, 3);
    mv(2, 0, 3);
    for (int i = 0; i < 3; i++) peek(i, 1);
    mv(2, 1, 6);
    peek(2, 0);
    $display("count test done");
    peek(0, 0);
    bus(1, QEC_OFF_CMD, 8'h05);
    ec[1] = 16'h0;
    rd16(0, 16'h0003);
    bus(1, QEC_OFF_CMD, 8'h03);
    rd16(1, 16'h0003);
    bus(1, QEC_OFF_CMD, 8'h07);
    mv(0, 1, 2);
    rd16(0, 16'h0003);
    rd16(1, 16'h0003);
    for (int i = 0; i < 3; i++) peek(i, 0);
    // a reset command offered while the clock enable is low must be lost
    clk_en = 0;
    bus(1, QEC_OFF_CMD, 8'h04);
    clk_en = 1;
    peek(0, 0);
    bus(0, 4'h3, 0);
    chk(b, QEC_RDATA_UNM);
    $display("command test done");
    bus(1, QEC_OFF_BOARD_RESET, 8'h5a);
    chk(local_reset, 1);
    ec = '{16'h0, 16'h0, 16'h0};
    rd16(0, 16'h0);
    for (int i = 0; i < 3; i++) peek(i, 1);
    $display("soft reset test done");
    // phase A left high across the release must not count
    resetn = 0;
    mv(0, 1, 1);
    hrst();
    mv(0, 1, 2);
    peek(0, 0);
    $display("hard reset test done");
    conclude();
  end
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
